// >>> design/bsx_dev.sv
// Behaviour
// - capture pin, enable and data each cell
// - capture and shift run on test clock
// - held update values drive during capture
// - enable update one tri-states the pin
// - enable update zero drives data update
// - shift captured values out on TDO
// - next pattern shifts in from TDI concurrently
// - update strobe copies shift into update
// - new update values drive core and pin
// - controller refuses external test until a sample preload has run
// - controller avoids external test during reconfiguration unless halted
// - halt instruction stops configuration for testing
// - configuration request held low pre-configuration
// - configured differential pins act as internal
// - standard instruction set supported
`timescale 1ns/10ps
`default_nettype none
`include "bsx_consts.svh"

module bsx_dev #(
    parameter int              NPIN      = 4,
    parameter logic [31:0]     ID_CODE   = 32'h0A5A_5001, // arbitrary value
    parameter logic [31:0]     USER_CODE = 32'h0000_0000,
    parameter logic [NPIN-1:0] DIFF_MASK = '0
) (
    input  wire logic            REF_CLK_I,
    input  wire logic            RST_I,
    bsx_if.dev                   LINK,
    input  wire logic [NPIN-1:0] CORE_OUT_I,
    input  wire logic [NPIN-1:0] CORE_OE_I,
    input  wire logic [NPIN-1:0] PIN_I,
    input  wire logic            IN_CIRCUIT_RECONFIG_I,
    input  wire logic            CONFIGURED_I,
    output logic      [NPIN-1:0] PIN_O,
    output logic      [NPIN-1:0] PIN_OE_O,
    output logic      [NPIN-1:0] CORE_IN_O,
    output logic                 CFG_HALT_O
);

    localparam int CW = NPIN * `BSX_CELLS_PER_PIN;
    localparam int SW = 3 * NPIN + 2;
    localparam int RW = CW + 3;

    // ==========================================================
    // test clock domain: input crossing
    logic          rst_t1_q;
    logic          rst_t2_q;
    logic [SW-1:0] in_s1_q;
    logic [SW-1:0] in_s2_q;

    // asserts at once: the test clock stands still while RST_I is held
    always_ff @(posedge LINK.tck or posedge RST_I)
    begin
        if (RST_I)
            {rst_t2_q, rst_t1_q} <= 2'h3;
        else
            {rst_t2_q, rst_t1_q} <= {rst_t1_q, 1'b0};
    end
    always_ff @(posedge LINK.tck)
    begin
        in_s1_q  <= {CONFIGURED_I, IN_CIRCUIT_RECONFIG_I, PIN_I, CORE_OE_I, CORE_OUT_I};
        in_s2_q  <= in_s1_q;
    end

    wire [NPIN-1:0] t_core_out = in_s2_q[NPIN-1:0];
    wire [NPIN-1:0] t_core_oe  = in_s2_q[2*NPIN-1:NPIN];
    wire [NPIN-1:0] t_pin      = in_s2_q[3*NPIN-1:2*NPIN];
    wire            t_icr      = in_s2_q[SW-2];
    wire            t_cfgd     = in_s2_q[SW-1];
    wire [NPIN-1:0] diff_int   = DIFF_MASK & {NPIN{t_cfgd}};

    // ==========================================================
    // TAP state machine
    bsx_pkg::bsx_tap_t tap_q;
    bsx_pkg::bsx_tap_t tap_d;
    wire               tms = LINK.tms;

    always_comb
    begin
        unique case (tap_q)
            bsx_pkg::TAP_RESET:  tap_d = tms ? bsx_pkg::TAP_RESET  : bsx_pkg::TAP_IDLE;
            bsx_pkg::TAP_IDLE:   tap_d = tms ? bsx_pkg::TAP_SEL_DR : bsx_pkg::TAP_IDLE;
            bsx_pkg::TAP_SEL_DR: tap_d = tms ? bsx_pkg::TAP_SEL_IR : bsx_pkg::TAP_CAP_DR;
            bsx_pkg::TAP_CAP_DR: tap_d = tms ? bsx_pkg::TAP_EX1_DR : bsx_pkg::TAP_SH_DR;
            bsx_pkg::TAP_SH_DR:  tap_d = tms ? bsx_pkg::TAP_EX1_DR : bsx_pkg::TAP_SH_DR;
            bsx_pkg::TAP_EX1_DR: tap_d = tms ? bsx_pkg::TAP_UPD_DR : bsx_pkg::TAP_PAU_DR;
            bsx_pkg::TAP_PAU_DR: tap_d = tms ? bsx_pkg::TAP_EX2_DR : bsx_pkg::TAP_PAU_DR;
            bsx_pkg::TAP_EX2_DR: tap_d = tms ? bsx_pkg::TAP_UPD_DR : bsx_pkg::TAP_SH_DR;
            bsx_pkg::TAP_UPD_DR: tap_d = tms ? bsx_pkg::TAP_SEL_DR : bsx_pkg::TAP_IDLE;
            bsx_pkg::TAP_SEL_IR: tap_d = tms ? bsx_pkg::TAP_RESET  : bsx_pkg::TAP_CAP_IR;
            bsx_pkg::TAP_CAP_IR: tap_d = tms ? bsx_pkg::TAP_EX1_IR : bsx_pkg::TAP_SH_IR;
            bsx_pkg::TAP_SH_IR:  tap_d = tms ? bsx_pkg::TAP_EX1_IR : bsx_pkg::TAP_SH_IR;
            bsx_pkg::TAP_EX1_IR: tap_d = tms ? bsx_pkg::TAP_UPD_IR : bsx_pkg::TAP_PAU_IR;
            bsx_pkg::TAP_PAU_IR: tap_d = tms ? bsx_pkg::TAP_EX2_IR : bsx_pkg::TAP_PAU_IR;
            bsx_pkg::TAP_EX2_IR: tap_d = tms ? bsx_pkg::TAP_UPD_IR : bsx_pkg::TAP_SH_IR;
            bsx_pkg::TAP_UPD_IR: tap_d = tms ? bsx_pkg::TAP_SEL_DR : bsx_pkg::TAP_IDLE;
        endcase
    end

    always_ff @(posedge LINK.tck or posedge rst_t2_q)
    begin
        if (rst_t2_q)
            tap_q <= bsx_pkg::TAP_RESET;
        else
            tap_q <= tap_d;
    end

    // ==========================================================
    // instruction decode
    logic [`BSX_IR_W-1:0] ir_sr_q;
    logic [`BSX_IR_W-1:0] ir_q;
    logic                 halt_q;

    wire [`BSX_IR_W-1:0] ir_nx = (tap_q == bsx_pkg::TAP_RESET) ? `BSX_OP_IDCODE
                               : (tap_q == bsx_pkg::TAP_UPD_IR) ? ir_sr_q : ir_q;
    wire op_bsr   = (ir_q == `BSX_OP_EXTEST) || (ir_q == `BSX_OP_SAMPLE);
    wire op_id    = (ir_q == `BSX_OP_IDCODE);
    wire op_user  = (ir_q == `BSX_OP_USERCODE);
    // external test is withheld while reconfiguration runs unhalted
    wire ext_ok   = (ir_nx == `BSX_OP_EXTEST) && !(t_icr && !halt_q);
    wire drive_d  = ext_ok || (ir_nx == `BSX_OP_CLAMP);
    wire highz_d  = (ir_nx == `BSX_OP_HIGHZ);
    wire cap_dr   = (tap_q == bsx_pkg::TAP_CAP_DR);
    wire sh_dr    = (tap_q == bsx_pkg::TAP_SH_DR);

    // ==========================================================
    // boundary cells
    logic [CW-1:0]        bsr_q;
    logic [CW-1:0]        upd_q;
    logic [CW-1:0]        cap_v;
    logic [`BSX_ID_W-1:0] id_sr_q;
    logic                 byp_q;
    logic                 drive_q;
    logic                 highz_q;
    logic                 tdo_q;

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_cell
            // configured differential pins capture core data, never the pad
            assign cap_v[3*gi+`BSX_CELL_IN]  = diff_int[gi] ? t_core_out[gi] : t_pin[gi];
            assign cap_v[3*gi+`BSX_CELL_OUT] = t_core_out[gi];
            assign cap_v[3*gi+`BSX_CELL_OE]  = t_core_oe[gi];
        end
    endgenerate

    always_ff @(posedge LINK.tck)
    begin
        if (cap_dr && op_bsr)
            bsr_q <= cap_v;
        else if (sh_dr && op_bsr)
            bsr_q <= {LINK.tdi, bsr_q[CW-1:1]};
        if (cap_dr)
            id_sr_q <= op_user ? USER_CODE : ID_CODE;
        else if (sh_dr)
            id_sr_q <= {LINK.tdi, id_sr_q[`BSX_ID_W-1:1]};
        byp_q <= sh_dr & LINK.tdi;
        if (tap_q == bsx_pkg::TAP_CAP_IR)
            ir_sr_q <= `BSX_IR_CAPTURE;
        else if (tap_q == bsx_pkg::TAP_SH_IR)
            ir_sr_q <= {LINK.tdi, ir_sr_q[`BSX_IR_W-1:1]};
    end

    wire dr_bit = op_bsr ? bsr_q[0] : (op_id || op_user) ? id_sr_q[0] : byp_q;
    wire tdo_d  = (tap_q == bsx_pkg::TAP_SH_IR) ? ir_sr_q[0] : sh_dr ? dr_bit : 1'b0;

    // update side runs on the falling edge so capture never disturbs it
    always_ff @(negedge LINK.tck or posedge rst_t2_q)
    begin
        if (rst_t2_q)
        begin
            ir_q    <= `BSX_OP_IDCODE;
            upd_q   <= '0;
            halt_q  <= 1'b0;
            drive_q <= 1'b0;
            highz_q <= 1'b0;
            tdo_q   <= 1'b0;
        end
        else
        begin
            ir_q <= ir_nx;
            if (tap_q == bsx_pkg::TAP_UPD_DR && op_bsr)
                upd_q <= bsr_q;
            if (tap_q == bsx_pkg::TAP_UPD_IR && ir_sr_q == `BSX_OP_CFG_HALT)
                halt_q <= 1'b1;
            drive_q <= drive_d;
            highz_q <= highz_d;
            tdo_q   <= tdo_d;
        end
    end

    assign LINK.tdo = tdo_q;

    // ==========================================================
    // core clock domain: pin and core side
    logic [RW-1:0]   out_s1_q;
    logic [RW-1:0]   out_s2_q;
    logic [NPIN-1:0] pin_s1_q;
    logic [NPIN-1:0] pin_s2_q;

    always_ff @(posedge REF_CLK_I)
    begin
        out_s1_q <= {halt_q, highz_q, drive_q, upd_q};
        out_s2_q <= out_s1_q;
        pin_s1_q <= PIN_I;
        pin_s2_q <= pin_s1_q;
    end

    wire [CW-1:0] r_upd   = out_s2_q[CW-1:0];
    wire          r_drive = out_s2_q[CW];
    wire          r_highz = out_s2_q[CW+1];
    logic [NPIN-1:0] pin_d;
    logic [NPIN-1:0] pin_oe_d;
    logic [NPIN-1:0] core_in_d;

    generate
        for (gi = 0; gi < NPIN; gi++)
        begin : g_pin
            wire tst = r_drive && !(DIFF_MASK[gi] && CONFIGURED_I);
            // update values hold the pin through capture and shift
            assign pin_d[gi]     = tst ? r_upd[3*gi+`BSX_CELL_OUT] : CORE_OUT_I[gi];
            assign pin_oe_d[gi]  = r_highz ? 1'b0
                                 : tst ? !r_upd[3*gi+`BSX_CELL_OE] : !CORE_OE_I[gi];
            assign core_in_d[gi] = tst ? r_upd[3*gi+`BSX_CELL_IN] : pin_s2_q[gi];
        end
    endgenerate

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            PIN_O      <= '0;
            PIN_OE_O   <= '0;
            CORE_IN_O  <= '0;
            CFG_HALT_O <= 1'b0;
        end
        else
        begin
            PIN_O      <= pin_d;
            PIN_OE_O   <= pin_oe_d;
            CORE_IN_O  <= core_in_d;
            CFG_HALT_O <= out_s2_q[CW+2];
        end
    end

endmodule : bsx_dev

`default_nettype wire

// >>> inc/bsx_consts.svh
`ifndef BSX_CONSTS_SVH
`define BSX_CONSTS_SVH

// ==========================================================
// instruction register
`define BSX_IR_W          4
`define BSX_IR_CAPTURE    4'h1
`define BSX_OP_EXTEST     4'h0
`define BSX_OP_SAMPLE     4'h5
`define BSX_OP_IDCODE     4'h6
`define BSX_OP_USERCODE   4'h7
`define BSX_OP_CLAMP      4'hA
`define BSX_OP_HIGHZ      4'hB
`define BSX_OP_CFG_HALT   4'hD
`define BSX_OP_BYPASS     4'hF

// ==========================================================
// data registers and sequencing
`define BSX_ID_W          32
`define BSX_CELLS_PER_PIN 3
`define BSX_CELL_IN       0
`define BSX_CELL_OUT      1
`define BSX_CELL_OE       2
`define BSX_TLR_CLOCKS    5
`define BSX_HOP_CLOCKS    4

`endif

// >>> inc/bsx_pkg.sv
package bsx_pkg;

    typedef enum logic [3:0] {
        TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR, TAP_PAU_DR,
        TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR, TAP_EX1_IR, TAP_PAU_IR,
        TAP_EX2_IR, TAP_UPD_IR
    } bsx_tap_t;

    typedef enum logic [2:0] {
        SEQ_RESET, SEQ_IDLE, SEQ_TO_IR, SEQ_SH_IR, SEQ_TO_DR, SEQ_SH_DR, SEQ_FIN
    } bsx_seq_t;

endpackage : bsx_pkg

// >>> inc/bsx_if.sv
`timescale 1ns/10ps
`default_nettype none

interface bsx_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;

    modport dev (input tck, input tms, input tdi, output tdo);
    modport ctl (output tck, output tms, output tdi, input tdo);
endinterface : bsx_if

`default_nettype wire

// >>> design/bsx_ctl.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsx_consts.svh"

module bsx_ctl #(
    parameter int DR_W = 32,
    parameter int HALF = 4,
    parameter int LW   = $clog2(DR_W + 1)
) (
    input  wire logic                 REF_CLK_I,
    input  wire logic                 RST_I,
    bsx_if.ctl                        LINK,
    input  wire logic                 START_I,
    input  wire logic [`BSX_IR_W-1:0] OPCODE_I,
    input  wire logic [DR_W-1:0]      DATA_I,
    input  wire logic [LW-1:0]        LEN_I,
    input  wire logic                 RECONFIG_BUSY_I,
    input  wire logic                 PRECFG_TEST_I,
    output logic      [DR_W-1:0]      DATA_O,
    output logic                      BUSY_O,
    output logic                      DONE_O,
    output logic                      REFUSED_O,
    output logic                      CONFIG_REQ_N_O
);

    // ==========================================================
    // test clock divider and return sampling
    logic [7:0] div_q;
    logic       tck_q;
    logic       tdo_s1_q;
    logic       tdo_s2_q;

    wire wrap = (div_q == 8'(HALF - 1));
    wire fall = wrap && tck_q;

    always_ff @(posedge REF_CLK_I)
    begin
        tdo_s1_q <= LINK.tdo;
        tdo_s2_q <= tdo_s1_q;
        if (RST_I)
        begin
            div_q <= '0;
            tck_q <= 1'b0;
        end
        else
        begin
            div_q <= wrap ? '0 : div_q + 8'h01;
            tck_q <= wrap ? !tck_q : tck_q;
        end
    end

    assign LINK.tck = tck_q;

    // ==========================================================
    // sequencer: one TMS step per falling edge
    bsx_pkg::bsx_seq_t    seq_q;
    logic [LW-1:0]        cnt_q;
    logic [LW-1:0]        len_q;
    logic [`BSX_IR_W-1:0] ir_q;
    logic [DR_W-1:0]      sh_q;
    logic [DR_W-1:0]      cap_q;
    logic                 pend_q;
    logic                 tms_q;
    logic                 tdi_q;
    logic                 preloaded_q;
    logic                 halted_q;

    wire is_ext  = (OPCODE_I == `BSX_OP_EXTEST);
    // pins must hold known values before external drive begins
    wire refuse  = is_ext && (!preloaded_q || (RECONFIG_BUSY_I && !halted_q));
    wire last_ir = (cnt_q == LW'(`BSX_IR_W - 1));
    wire last_dr = (cnt_q == len_q - LW'(1));
    wire hop_end = (cnt_q == LW'(`BSX_HOP_CLOCKS - 1));
    wire take    = START_I && (seq_q == bsx_pkg::SEQ_IDLE);
    wire [DR_W-1:0] cap_nx = {tdo_s2_q, cap_q[DR_W-1:1]};

    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
        begin
            seq_q       <= bsx_pkg::SEQ_RESET;
            cnt_q       <= '0;
            len_q       <= '0;
            ir_q        <= '0;
            sh_q        <= '0;
            cap_q       <= '0;
            pend_q      <= 1'b0;
            tms_q       <= 1'b1;
            tdi_q       <= 1'b0;
            preloaded_q <= 1'b0;
            halted_q    <= 1'b0;
            DATA_O      <= '0;
            BUSY_O      <= 1'b1;
            DONE_O      <= 1'b0;
            REFUSED_O   <= 1'b0;
        end
        else
        begin
            DONE_O    <= 1'b0;
            REFUSED_O <= take && refuse;
            if (take && !refuse)
            begin
                seq_q  <= bsx_pkg::SEQ_TO_IR;
                cnt_q  <= '0;
                ir_q   <= OPCODE_I;
                sh_q   <= DATA_I;
                len_q  <= LEN_I;
                BUSY_O <= 1'b1;
            end
            else if (fall)
            begin
                // bit returned for the previous shift edge
                if (pend_q)
                    cap_q <= cap_nx;
                pend_q <= 1'b0;
                tdi_q  <= 1'b0;
                cnt_q  <= cnt_q + LW'(1);
                unique case (seq_q)
                    bsx_pkg::SEQ_RESET:
                    begin
                        tms_q <= (cnt_q < LW'(`BSX_TLR_CLOCKS));
                        if (cnt_q == LW'(`BSX_TLR_CLOCKS))
                        begin
                            seq_q  <= bsx_pkg::SEQ_IDLE;
                            BUSY_O <= 1'b0;
                        end
                    end
                    bsx_pkg::SEQ_IDLE:
                    begin
                        tms_q <= 1'b0;
                        cnt_q <= '0;
                    end
                    bsx_pkg::SEQ_TO_IR:
                    begin
                        tms_q <= (cnt_q < LW'(2));
                        if (hop_end)
                        begin
                            seq_q <= bsx_pkg::SEQ_SH_IR;
                            cnt_q <= '0;
                        end
                    end
                    bsx_pkg::SEQ_SH_IR:
                    begin
                        tms_q <= last_ir;
                        tdi_q <= ir_q[0];
                        ir_q  <= ir_q >> 1;
                        if (last_ir)
                        begin
                            seq_q <= bsx_pkg::SEQ_TO_DR;
                            cnt_q <= '0;
                        end
                    end
                    bsx_pkg::SEQ_TO_DR:
                    begin
                        tms_q <= (cnt_q < LW'(2));
                        if (hop_end)
                        begin
                            seq_q <= bsx_pkg::SEQ_SH_DR;
                            cnt_q <= '0;
                        end
                    end
                    bsx_pkg::SEQ_SH_DR:
                    begin
                        tms_q  <= last_dr;
                        tdi_q  <= sh_q[0];
                        sh_q   <= sh_q >> 1;
                        pend_q <= 1'b1;
                        if (last_dr)
                        begin
                            seq_q <= bsx_pkg::SEQ_FIN;
                            cnt_q <= '0;
                        end
                    end
                    bsx_pkg::SEQ_FIN:
                    begin
                        tms_q <= (cnt_q == '0);
                        if (cnt_q != '0)
                        begin
                            seq_q  <= bsx_pkg::SEQ_IDLE;
                            BUSY_O <= 1'b0;
                            DONE_O <= 1'b1;
                            DATA_O <= cap_q >> (DR_W - int'(len_q));
                        end
                    end
                endcase
            end
            if (take && !refuse && OPCODE_I == `BSX_OP_SAMPLE)
                preloaded_q <= 1'b1;
            if (take && !refuse && OPCODE_I == `BSX_OP_CFG_HALT)
                halted_q <= 1'b1;
        end
    end

    assign LINK.tms = tms_q;
    assign LINK.tdi = tdi_q;

    // ==========================================================
    // configuration request held low for pre-configuration test
    always_ff @(posedge REF_CLK_I)
    begin
        if (RST_I)
            CONFIG_REQ_N_O <= 1'b1;
        else
            CONFIG_REQ_N_O <= !PRECFG_TEST_I;
    end

endmodule : bsx_ctl

`default_nettype wire

// >>> dv/bsx_monitor.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsx_consts.svh"

module bsx_monitor (
    input wire logic REF_CLK_I,
    input wire logic RST_I,
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo
);
    // ==========================================================
    // tap tracker, rebuilt from the wire
    bsx_pkg::bsx_tap_t st_q;
    bsx_pkg::bsx_tap_t st_d;
    logic [3:0]        ir_sh_q;
    logic [3:0]        ir_q;
    logic [5:0]        cnt_q;
    logic [3:0]        ir_cap;
    wire               sh_dr = (st_q == bsx_pkg::TAP_SH_DR);
    wire               sh_ir = (st_q == bsx_pkg::TAP_SH_IR);
    // these instructions all select the one-bit bypass path
    wire               byp   = (ir_q == `BSX_OP_BYPASS) || (ir_q == `BSX_OP_CLAMP) ||
                               (ir_q == `BSX_OP_HIGHZ) || (ir_q == `BSX_OP_CFG_HALT);
    assign ir_cap = `BSX_IR_CAPTURE;

    always_comb
    begin
        case (st_q)
            bsx_pkg::TAP_RESET:  st_d = tms ? bsx_pkg::TAP_RESET  : bsx_pkg::TAP_IDLE;
            bsx_pkg::TAP_IDLE:   st_d = tms ? bsx_pkg::TAP_SEL_DR : bsx_pkg::TAP_IDLE;
            bsx_pkg::TAP_SEL_DR: st_d = tms ? bsx_pkg::TAP_SEL_IR : bsx_pkg::TAP_CAP_DR;
            bsx_pkg::TAP_CAP_DR: st_d = tms ? bsx_pkg::TAP_EX1_DR : bsx_pkg::TAP_SH_DR;
            bsx_pkg::TAP_SH_DR:  st_d = tms ? bsx_pkg::TAP_EX1_DR : bsx_pkg::TAP_SH_DR;
            bsx_pkg::TAP_EX1_DR: st_d = tms ? bsx_pkg::TAP_UPD_DR : bsx_pkg::TAP_PAU_DR;
            bsx_pkg::TAP_PAU_DR: st_d = tms ? bsx_pkg::TAP_EX2_DR : bsx_pkg::TAP_PAU_DR;
            bsx_pkg::TAP_EX2_DR: st_d = tms ? bsx_pkg::TAP_UPD_DR : bsx_pkg::TAP_SH_DR;
            bsx_pkg::TAP_UPD_DR: st_d = tms ? bsx_pkg::TAP_SEL_DR : bsx_pkg::TAP_IDLE;
            bsx_pkg::TAP_SEL_IR: st_d = tms ? bsx_pkg::TAP_RESET  : bsx_pkg::TAP_CAP_IR;
            bsx_pkg::TAP_CAP_IR: st_d = tms ? bsx_pkg::TAP_EX1_IR : bsx_pkg::TAP_SH_IR;
            bsx_pkg::TAP_SH_IR:  st_d = tms ? bsx_pkg::TAP_EX1_IR : bsx_pkg::TAP_SH_IR;
            bsx_pkg::TAP_EX1_IR: st_d = tms ? bsx_pkg::TAP_UPD_IR : bsx_pkg::TAP_PAU_IR;
            bsx_pkg::TAP_PAU_IR: st_d = tms ? bsx_pkg::TAP_EX2_IR : bsx_pkg::TAP_PAU_IR;
            bsx_pkg::TAP_EX2_IR: st_d = tms ? bsx_pkg::TAP_UPD_IR : bsx_pkg::TAP_SH_IR;
            default:             st_d = tms ? bsx_pkg::TAP_SEL_DR : bsx_pkg::TAP_IDLE;
        endcase
    end

    // async reset: tck is stopped while reset is held
    always_ff @(posedge tck or posedge RST_I)
    begin
        if (RST_I)
        begin
            st_q    <= bsx_pkg::TAP_RESET;
            ir_q    <= `BSX_OP_IDCODE;
            ir_sh_q <= 4'h0;
            cnt_q   <= 6'h00;
        end
        else
        begin
            st_q    <= st_d;
            cnt_q   <= (sh_dr || sh_ir) ? cnt_q + 6'h01 : 6'h00;
            ir_sh_q <= sh_ir ? {tdi, ir_sh_q[3:1]} : ir_sh_q;
            if (st_q == bsx_pkg::TAP_UPD_IR)
                ir_q <= ir_sh_q;
            else if (st_q == bsx_pkg::TAP_RESET)
                ir_q <= `BSX_OP_IDCODE;
        end
    end

    // ==========================================================
    // link side
    a_tdo_idle_low: assert property (@(posedge tck) disable iff (RST_I)
        !(sh_dr || sh_ir) |-> tdo == 1'b0) else $error("tdo not low outside shift");
    a_ir_capture_out: assert property (@(posedge tck) disable iff (RST_I)
        sh_ir && cnt_q < 6'h04 |-> tdo == ir_cap[cnt_q[1:0]])
        else $error("wrong instruction capture bit");
    a_bypass_delay: assert property (@(posedge tck) disable iff (RST_I)
        sh_dr && byp && cnt_q != 6'h00 |-> tdo == $past(tdi)) else $error("bypass bit wrong");
    a_bypass_first_zero: assert property (@(posedge tck) disable iff (RST_I)
        sh_dr && byp && cnt_q == 6'h00 |-> !tdo) else $error("bypass capture not zero");
    a_idcode_lsb_one: assert property (@(posedge tck) disable iff (RST_I)
        sh_dr && ir_q == `BSX_OP_IDCODE && cnt_q == 6'h00 |-> tdo)
        else $error("identity lsb not one");
    a_update_then_idle: assert property (@(posedge tck) disable iff (RST_I)
        st_q == bsx_pkg::TAP_UPD_DR |-> !tms) else $error("no return to idle after update");
    a_tms_on_fall: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $changed(tms) |-> $fell(tck)) else $error("tms moved off the falling edge");
    a_tdi_on_fall: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $changed(tdi) |-> $fell(tck)) else $error("tdi moved off the falling edge");
    a_tdo_on_fall: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $changed(tdo) |-> $fell(tck)) else $error("tdo moved off the falling edge");
    a_tck_high_len: assert property (@(posedge REF_CLK_I) disable iff (RST_I)
        $rose(tck) |-> tck [*4] ##1 !tck) else $error("tck high phase wrong");

    c_extest_update: cover property (@(posedge tck) disable iff (RST_I)
        st_q == bsx_pkg::TAP_UPD_DR && ir_q == `BSX_OP_EXTEST);
    c_bypass_shift: cover property (@(posedge tck) disable iff (RST_I) sh_dr && byp);
    c_ir_shift: cover property (@(posedge tck) disable iff (RST_I) sh_ir);
endmodule : bsx_monitor

`default_nettype wire

// >>> dv/boundary_scan_extest_cell_bench.sv
`timescale 1ns/10ps
`default_nettype none
`include "bsx_consts.svh"

module boundary_scan_extest_cell_bench;
    // ==========================================================
    // stimulus and wiring
    typedef struct {logic [3:0] op; logic [31:0] d; logic [5:0] n; logic [31:0] ex; logic rf;}
        bsx_row_t;
    localparam logic [31:0] ID   = 32'h1357_9BDF; // arbitrary value
    localparam logic [31:0] USER = 32'h0000_1234;
    logic        clk = 1'b0;
    logic        rst = 1'b0;
    logic [3:0]  core_out = 4'h6;
    logic [3:0]  core_oe = 4'h3;
    logic [3:0]  pin_ext = 4'h9;
    logic        reconfig = 1'b0;
    logic        configured = 1'b0;
    logic        precfg = 1'b0;
    logic        start = 1'b0;
    logic [3:0]  opcode = 4'h0;
    logic [31:0] data = 32'h0;
    logic [5:0]  len = 6'h01;
    logic [3:0]  pin_o, pin_oe, core_in;
    logic        halt, busy, done, refused, cfg_req_n, got_ref;
    logic [31:0] data_o;
    wire  [3:0]  pad = (pin_oe & pin_o) | (~pin_oe & pin_ext);
    int          fails = 0;
    int          samples_checked = 0;
    bsx_row_t    rows [5];

    bsx_if link ();
    bsx_dev #(.NPIN(4), .ID_CODE(ID), .USER_CODE(USER), .DIFF_MASK(4'h8)) bsx_dev_inst (
        .REF_CLK_I(clk), .RST_I(rst), .LINK(link.dev), .CORE_OUT_I(core_out),
        .CORE_OE_I(core_oe), .PIN_I(pad), .IN_CIRCUIT_RECONFIG_I(reconfig),
        .CONFIGURED_I(configured), .PIN_O(pin_o), .PIN_OE_O(pin_oe), .CORE_IN_O(core_in),
        .CFG_HALT_O(halt));
    bsx_ctl #(.DR_W(32), .HALF(4)) bsx_ctl_inst (
        .REF_CLK_I(clk), .RST_I(rst), .LINK(link.ctl), .START_I(start), .OPCODE_I(opcode),
        .DATA_I(data), .LEN_I(len), .RECONFIG_BUSY_I(reconfig), .PRECFG_TEST_I(precfg),
        .DATA_O(data_o), .BUSY_O(busy), .DONE_O(done), .REFUSED_O(refused),
        .CONFIG_REQ_N_O(cfg_req_n));
    bsx_monitor bsx_monitor_inst (
        .REF_CLK_I(clk), .RST_I(rst), .tck(link.tck), .tms(link.tms), .tdi(link.tdi),
        .tdo(link.tdo));

    initial
    begin
        forever #12.5 clk = ~clk;
    end

    // ==========================================================
    // helpers
    function automatic logic [31:0] cap(input logic [3:0] pd, input logic [3:0] o,
                                        input logic [3:0] e);
        cap = 32'h0;
        for (int i = 0; i < 4; i++) cap[3*i +: 3] = {e[i], o[i], pd[i]};
    endfunction : cap

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fails++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out;
        $display("checks=%0d fails=%0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : close_out

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick

    // one full instruction plus data scan; waits are bounded
    task automatic run(input logic [3:0] op, input logic [31:0] d, input logic [5:0] n);
        int k;
        k = 0;
        while (busy !== 1'b0 && k < 3000)
        begin
            tick(1);
            k++;
        end
        @(posedge clk);
        start  <= 1'b1;
        opcode <= op;
        data   <= d;
        len    <= n;
        @(posedge clk);
        start  <= 1'b0;
        #1;
        while (done !== 1'b1 && refused !== 1'b1 && k < 6000)
        begin
            tick(1);
            k++;
        end
        if (k >= 6000)
        begin
            fails++;
            close_out();
        end
        got_ref = refused;
        tick(8);
    endtask : run

    // ==========================================================
    // main sequence
    initial
    begin
        rst <= 1'b1;
        rows[0] = '{`BSX_OP_EXTEST, 32'h0, 6'd12, 32'h0, 1'b1};
        rows[1] = '{`BSX_OP_IDCODE, 32'h0, 6'd32, ID, 1'b0};
        rows[2] = '{`BSX_OP_USERCODE, 32'h0, 6'd32, USER, 1'b0};
        rows[3] = '{`BSX_OP_BYPASS, 32'hA5, 6'd8, 32'h4A, 1'b0};
        rows[4] = '{`BSX_OP_SAMPLE, cap(4'h0, 4'h2, 4'h9), 6'd12, cap(4'h5, 4'h6, 4'h3), 1'b0};
        tick(3);
        check(pin_oe, 4'h0);
        check(cfg_req_n, 1'b1);
        tick(2);
        @(posedge clk) rst <= 1'b0;
        foreach (rows[i])
        begin
            run(rows[i].op, rows[i].d, rows[i].n);
            check(got_ref, rows[i].rf);
            if (!rows[i].rf)
                check(data_o & ((32'h1 << rows[i].n) - 32'h1), rows[i].ex);
        end
        // preloaded values drive during capture, new pattern after update
        run(`BSX_OP_EXTEST, cap(4'hA, 4'h5, 4'h6), 6'd12);
        check(data_o & 32'h249, cap(4'hB, 4'h0, 4'h0));
        check(pin_oe, 4'h9);
        check(pin_o & 4'h9, 4'h1);
        check(core_in, 4'hA);
        run(`BSX_OP_EXTEST, cap(4'h3, 4'hF, 4'h0), 6'd12);
        check(data_o & 32'h249, cap(4'h1, 4'h0, 4'h0));
        check({pin_oe, pin_o, core_in}, 12'hFF3);
        run(`BSX_OP_CLAMP, 32'h0, 6'd4);
        check(pin_oe, 4'hF);
        run(`BSX_OP_HIGHZ, 32'h0, 6'd4);
        check(pin_oe, 4'h0);
        @(posedge clk) reconfig <= 1'b1;
        run(`BSX_OP_EXTEST, 32'h0, 6'd12);
        check(got_ref, 1'b1);
        run(`BSX_OP_CFG_HALT, 32'h0, 6'd4);
        check(halt, 1'b1);
        run(`BSX_OP_EXTEST, 32'h0, 6'd12);
        check(got_ref, 1'b0);
        @(posedge clk) precfg <= 1'b1;
        tick(3);
        check(cfg_req_n, 1'b0);
        @(posedge clk)
        begin
            configured <= 1'b1;
            core_oe    <= 4'hB;
        end
        run(`BSX_OP_SAMPLE, 32'h0, 6'd12);
        check(data_o[9], 1'b0);
        close_out();
    end
endmodule : boundary_scan_extest_cell_bench

`default_nettype wire
